// ===== rtl/oeil_top.sv
// How it works
// R1: Status read returns the live monitored conditions, never a latched copy.
// R2: Status bits 8,7,4,2,1 carry SE0-idle, session end, connect, pulse, valid.
// R3: Status bit 3 shows the synchronised cable type pin.
// R4: Status bit 0 shows bus power valid; bit 7 shows session end.
// R5: After reset bits 7,3,1,0 follow their lines; others read zero.
// R6: A latch bit sets on an edge armed by an enable register or on a one written to the set address.
// R7: Latch has set and clear addresses, sixteen bits, resets to zero.
// R8: Latch bits 9,6,5 record timer expiry, disconnect-connect, resume.
// R9: Latch bits 3 and 0 record cable pin and power valid changes.
// R10: Latch bit 10 is read-only; reserved bits are written as zero.
// R11: Falling enable register arms latching on high-to-low transitions.
// R12: Falling bit 8 latches when a long SE0 ends.
// R13: Falling bit 7 latches when session end goes away.
// R14: Falling bit 4 latches when remote connect goes away.
// R15: Falling bit 3 latches on cable type pin falling.
// R16: Falling bit 1 latches when session valid is lost.
// R17: Falling bit 0 latches when bus power valid falls.
// R18: Falling bits 15-9, 6-5 and 2 are reserved and never arm.
// R19: Rising enable register arms latching on low-to-high transitions.
// R20: Ones written set or clear; zeros hold; both addresses read.
// R21: Interrupt request stays high while any latch bit is set.
`timescale 1ns/10ps
`include "oeil_params.svh"

module oeil_top (
  // Clock and reset.
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  // Register port.
  input  wire logic [`OEIL_AW-1:0]   reg_addr,
  input  wire logic                  reg_wr_en,
  input  wire logic                  reg_rd_en,
  input  wire oeil_pkg::oeil_word_t  reg_wdata,
  output oeil_pkg::oeil_word_t       reg_rdata_ff,
  output logic                       reg_rdata_valid_ff,
  output logic                       reg_access_err_ff,
  // Line and session monitors, asynchronous.
  input  wire logic                  long_single_ended_zero_idle,
  input  wire logic                  session_end_low_bus_voltage,
  input  wire logic                  remote_connect_detect,
  input  wire logic                  cable_type_pin,
  input  wire logic                  dplus_pulse_session_request,
  input  wire logic                  session_valid,
  input  wire logic                  bus_power_valid,
  // Controller events, on core_clk.
  input  wire logic                  role_timer_expired,
  input  wire logic                  b_disconnect_a_connect_event,
  input  wire logic                  j_to_k_resume_event,
  // Interrupt and state view.
  output logic                       otg_irq_ff,
  output oeil_pkg::oeil_word_t       otg_live_condition_status_ff,
  output oeil_pkg::oeil_word_t       otg_latch_ff
);

  // Synchronised monitor lines.
  logic [`OEIL_NUM_LINES-1:0] line_raw;
  logic [`OEIL_NUM_LINES-1:0] line_sync_ff;

  // Synchronised lines by name.
  logic se0_idle_sync;
  logic sess_end_sync;
  logic connect_sync;
  logic cable_sync;
  logic dplus_pulse_sync;
  logic sess_valid_sync;
  logic power_valid_sync;

  // Source levels and edges.
  oeil_pkg::oeil_word_t live_word;
  oeil_pkg::oeil_word_t event_word;
  oeil_pkg::oeil_word_t event_ff;
  oeil_pkg::oeil_word_t src_word;
  oeil_pkg::oeil_word_t src_prev_ff;
  oeil_pkg::oeil_word_t nxt_status;
  oeil_pkg::oeil_word_t rise_edge;
  oeil_pkg::oeil_word_t fall_edge;
  oeil_pkg::oeil_word_t latch_hw_set;

  // Stored registers.
  oeil_pkg::oeil_word_t latch_q;
  oeil_pkg::oeil_word_t fall_en_q;
  oeil_pkg::oeil_word_t rise_en_q;

  // Address decode.
  logic hit_status;
  logic hit_latch_set;
  logic hit_latch_clr;
  logic hit_fall_set;
  logic hit_fall_clr;
  logic hit_rise_set;
  logic hit_rise_clr;
  logic hit_any;
  oeil_pkg::oeil_sel_e rd_sel;

  // Software set and clear masks.
  oeil_pkg::oeil_word_t latch_sw_set;
  oeil_pkg::oeil_word_t latch_sw_clr;
  oeil_pkg::oeil_word_t fall_sw_set;
  oeil_pkg::oeil_word_t fall_sw_clr;
  oeil_pkg::oeil_word_t rise_sw_set;
  oeil_pkg::oeil_word_t rise_sw_clr;

  // Access checks and read data.
  logic                 wr_latch;
  logic                 wr_fall;
  logic                 wr_rise;
  logic                 err_unmapped;
  logic                 err_ro_write;
  logic                 err_reserved;
  logic                 err_rsv_latch;
  logic                 err_rsv_fall;
  logic                 err_rsv_rise;
  logic                 nxt_irq;
  logic                 nxt_err;
  oeil_pkg::oeil_word_t rd_word;

  // Monitor lines come from analog comparators and a pin.
  assign line_raw = {
    long_single_ended_zero_idle,
    session_end_low_bus_voltage,
    remote_connect_detect,
    cable_type_pin,
    dplus_pulse_session_request,
    session_valid,
    bus_power_valid
  };

  oeil_sync #(
    .WIDTH (`OEIL_NUM_LINES)
  ) u_line_sync (
    .core_clk (core_clk),
    .async_in (line_raw),
    .sync_ff  (line_sync_ff)
  );

  // Name each synchronised line.
  assign se0_idle_sync    = line_sync_ff[`OEIL_LINE_SE0];
  assign sess_end_sync    = line_sync_ff[`OEIL_LINE_SESS_END];
  assign connect_sync     = line_sync_ff[`OEIL_LINE_CONNECT];
  assign cable_sync       = line_sync_ff[`OEIL_LINE_CABLE];
  assign dplus_pulse_sync = line_sync_ff[`OEIL_LINE_DP_PULSE];
  assign sess_valid_sync  = line_sync_ff[`OEIL_LINE_SESS_VLD];
  assign power_valid_sync = line_sync_ff[`OEIL_LINE_VBUS];

  // Live condition word in status bit positions.
  always_comb begin
    live_word = `OEIL_ZERO;
    live_word[`OEIL_BIT_SE0]      = se0_idle_sync; // R2
    live_word[`OEIL_BIT_SESS_END] = sess_end_sync; // R4
    live_word[`OEIL_BIT_RMT]      = connect_sync; // R2
    live_word[`OEIL_BIT_CABLE]    = cable_sync; // R3
    live_word[`OEIL_BIT_DP_PULSE] = dplus_pulse_sync; // R2
    live_word[`OEIL_BIT_SESS_VLD] = sess_valid_sync; // R2
    live_word[`OEIL_BIT_VBUS]     = power_valid_sync; // R4
  end

  // Controller events in latch bit positions.
  always_comb begin
    event_word = `OEIL_ZERO;
    event_word[`OEIL_BIT_TIMER]  = role_timer_expired; // R8
    event_word[`OEIL_BIT_BDIS]   = b_disconnect_a_connect_event; // R8
    event_word[`OEIL_BIT_RESUME] = j_to_k_resume_event; // R8
  end

  // Status tracks the lines every cycle; reserved bits stay zero.
  assign nxt_status = live_word & `OEIL_STATUS_MASK; // R1

  always_ff @(posedge core_clk) begin
    if (reset) begin
      otg_live_condition_status_ff <= nxt_status & `OEIL_LIVE_RESET_MASK; // R5
    end else begin
      otg_live_condition_status_ff <= nxt_status; // R1
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      event_ff <= `OEIL_ZERO;
    end else begin
      event_ff <= event_word & `OEIL_EVENT_MASK;
    end
  end

  // All sources side by side, one bit per latch position.
  assign src_word = otg_live_condition_status_ff | event_ff;

  // The previous value is loaded under reset; release can still show rises on status bits 8, 4 and 2.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      src_prev_ff <= src_word;
    end else begin
      src_prev_ff <= src_word;
    end
  end

  assign rise_edge = src_word & ~src_prev_ff;
  assign fall_edge = ~src_word & src_prev_ff;

  // Only armed edges reach the latch.
  assign latch_hw_set = ((rise_edge & rise_en_q) // R19
                       | (fall_edge & fall_en_q)) // R11
                       & `OEIL_LATCH_MASK; // R6

  // Address decode.
  assign hit_status    = (reg_addr == `OEIL_ADDR_STATUS);
  assign hit_latch_set = (reg_addr == `OEIL_ADDR_LATCH_SET); // R7
  assign hit_latch_clr = (reg_addr == `OEIL_ADDR_LATCH_CLR); // R7
  assign hit_fall_set  = (reg_addr == `OEIL_ADDR_FALL_SET); // R11
  assign hit_fall_clr  = (reg_addr == `OEIL_ADDR_FALL_CLR); // R11
  assign hit_rise_set  = (reg_addr == `OEIL_ADDR_RISE_SET); // R19
  assign hit_rise_clr  = (reg_addr == `OEIL_ADDR_RISE_CLR); // R19

  assign hit_any = hit_status
                 | hit_latch_set | hit_latch_clr
                 | hit_fall_set  | hit_fall_clr
                 | hit_rise_set  | hit_rise_clr;

  // Either address of a pair reads the same register.
  assign rd_sel = hit_status                    ? oeil_pkg::oeil_sel_status :
                  (hit_latch_set | hit_latch_clr) ? oeil_pkg::oeil_sel_latch :
                  (hit_fall_set  | hit_fall_clr)  ? oeil_pkg::oeil_sel_fall :
                  (hit_rise_set  | hit_rise_clr)  ? oeil_pkg::oeil_sel_rise :
                  oeil_pkg::oeil_sel_none; // R20

  // Write strobes turned into set and clear masks.
  assign latch_sw_set = (reg_wr_en & hit_latch_set) ? reg_wdata
                                                    : `OEIL_ZERO; // R20
  assign latch_sw_clr = (reg_wr_en & hit_latch_clr) ? reg_wdata
                                                    : `OEIL_ZERO; // R20
  assign fall_sw_set  = (reg_wr_en & hit_fall_set)  ? reg_wdata
                                                    : `OEIL_ZERO;
  assign fall_sw_clr  = (reg_wr_en & hit_fall_clr)  ? reg_wdata
                                                    : `OEIL_ZERO;
  assign rise_sw_set  = (reg_wr_en & hit_rise_set)  ? reg_wdata
                                                    : `OEIL_ZERO;
  assign rise_sw_clr  = (reg_wr_en & hit_rise_clr)  ? reg_wdata
                                                    : `OEIL_ZERO;

  // Latch: bit 10 and bits above 9 are never stored.
  oeil_setclr_reg #(
    .IMPL_MASK (`OEIL_LATCH_MASK) // R10
  ) u_latch (
    .core_clk (core_clk),
    .reset    (reset),
    .sw_set   (latch_sw_set),
    .sw_clr   (latch_sw_clr),
    .hw_set   (latch_hw_set), // R9
    .q_ff     (latch_q)
  );

  // Falling enable: only bits 8, 7, 4, 3, 1 and 0 can arm.
  oeil_setclr_reg #(
    .IMPL_MASK (`OEIL_FALL_MASK) // R18
  ) u_fall_en (
    .core_clk (core_clk),
    .reset    (reset),
    .sw_set   (fall_sw_set), // R12 R13 R14 R15 R16 R17
    .sw_clr   (fall_sw_clr),
    .hw_set   (`OEIL_ZERO),
    .q_ff     (fall_en_q)
  );

  // Rising enable: every implemented latch bit can arm.
  oeil_setclr_reg #(
    .IMPL_MASK (`OEIL_RISE_MASK) // R19
  ) u_rise_en (
    .core_clk (core_clk),
    .reset    (reset),
    .sw_set   (rise_sw_set),
    .sw_clr   (rise_sw_clr),
    .hw_set   (`OEIL_ZERO),
    .q_ff     (rise_en_q)
  );

  assign otg_latch_ff = latch_q;

  // Read multiplexer.
  always_comb begin
    rd_word = `OEIL_ZERO;
    case (rd_sel)
      oeil_pkg::oeil_sel_status: begin
        rd_word = otg_live_condition_status_ff; // R1
      end
      oeil_pkg::oeil_sel_latch: begin
        rd_word = latch_q;
      end
      oeil_pkg::oeil_sel_fall: begin
        rd_word = fall_en_q;
      end
      oeil_pkg::oeil_sel_rise: begin
        rd_word = rise_en_q;
      end
      default: begin
        rd_word = `OEIL_ZERO;
      end
    endcase
  end

  // Access checks: unmapped address, write to status, reserved ones.
  assign wr_latch = reg_wr_en & (hit_latch_set | hit_latch_clr);
  assign wr_fall  = reg_wr_en & (hit_fall_set  | hit_fall_clr);
  assign wr_rise  = reg_wr_en & (hit_rise_set  | hit_rise_clr);

  assign err_unmapped = (reg_wr_en | reg_rd_en) & ~hit_any;
  assign err_ro_write = reg_wr_en & hit_status;
  assign err_rsv_latch = wr_latch & (|(reg_wdata & ~`OEIL_LATCH_MASK)); // R10
  assign err_rsv_fall  = wr_fall  & (|(reg_wdata & ~`OEIL_FALL_MASK));
  assign err_rsv_rise  = wr_rise  & (|(reg_wdata & ~`OEIL_RISE_MASK));
  assign err_reserved  = err_rsv_latch | err_rsv_fall | err_rsv_rise;

  assign nxt_err = err_unmapped | err_ro_write | err_reserved;

  // Read data stands until the next read.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata_ff <= `OEIL_ZERO;
    end else if (reg_rd_en) begin
      reg_rdata_ff <= rd_word;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata_valid_ff <= 1'b0;
      reg_access_err_ff  <= 1'b0;
    end else begin
      reg_rdata_valid_ff <= reg_rd_en;
      reg_access_err_ff  <= nxt_err;
    end
  end

  // Any stored latch bit asks for service.
  assign nxt_irq = |(latch_q & `OEIL_LATCH_MASK); // R21

  // Request follows the stored latch one cycle later.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      otg_irq_ff <= 1'b0;
    end else begin
      otg_irq_ff <= nxt_irq; // R21
    end
  end

endmodule : oeil_top

// ===== shared/oeil_params.svh
`ifndef OEIL_PARAMS_SVH
`define OEIL_PARAMS_SVH

// Register port widths.
`define OEIL_DW 16
`define OEIL_AW 16

// Register addresses.
`define OEIL_ADDR_STATUS    16'h0378
`define OEIL_ADDR_LATCH_SET 16'h037C
`define OEIL_ADDR_LATCH_CLR 16'h037E
`define OEIL_ADDR_FALL_SET  16'h0380
`define OEIL_ADDR_FALL_CLR  16'h0382
`define OEIL_ADDR_RISE_SET  16'h0384
`define OEIL_ADDR_RISE_CLR  16'h0386

// Bit positions shared by status, latch and both enables.
`define OEIL_BIT_TIMER    9
`define OEIL_BIT_SE0      8
`define OEIL_BIT_SESS_END 7
`define OEIL_BIT_BDIS     6
`define OEIL_BIT_RESUME   5
`define OEIL_BIT_RMT      4
`define OEIL_BIT_CABLE    3
`define OEIL_BIT_DP_PULSE 2
`define OEIL_BIT_SESS_VLD 1
`define OEIL_BIT_VBUS     0

// Field masks and reset values.
`define OEIL_ZERO            16'h0000
`define OEIL_STATUS_MASK     16'h019F
`define OEIL_LIVE_RESET_MASK 16'h008B
`define OEIL_LATCH_MASK      16'h03FF
`define OEIL_FALL_MASK       16'h019B
`define OEIL_RISE_MASK       16'h03FF
`define OEIL_EVENT_MASK      16'h0260

// Number of monitor lines that pass the synchroniser.
`define OEIL_NUM_LINES 7

// Monitor line positions in the synchroniser word.
`define OEIL_LINE_SE0      6
`define OEIL_LINE_SESS_END 5
`define OEIL_LINE_CONNECT  4
`define OEIL_LINE_CABLE    3
`define OEIL_LINE_DP_PULSE 2
`define OEIL_LINE_SESS_VLD 1
`define OEIL_LINE_VBUS     0

`endif

// ===== shared/oeil_pkg.sv
`include "oeil_params.svh"

package oeil_pkg;

  typedef logic [`OEIL_DW-1:0] oeil_word_t;

  typedef enum logic [2:0] {
    oeil_sel_none,
    oeil_sel_status,
    oeil_sel_latch,
    oeil_sel_fall,
    oeil_sel_rise
  } oeil_sel_e;

endpackage : oeil_pkg

// ===== rtl/oeil_sync.sv
`timescale 1ns/10ps

module oeil_sync #(
  parameter int WIDTH = 1
) (
  // Clock.
  input  wire logic             core_clk,
  // Asynchronous lines and their synchronised copy.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_ff
);

  logic [WIDTH-1:0] meta_ff;

  // Two stages; only the second stage reads the first.
  always_ff @(posedge core_clk) begin
    meta_ff <= async_in;
    sync_ff <= meta_ff;
  end

endmodule : oeil_sync

// ===== rtl/oeil_setclr_reg.sv
`timescale 1ns/10ps
`include "oeil_params.svh"

module oeil_setclr_reg #(
  parameter logic [`OEIL_DW-1:0] IMPL_MASK = 16'hFFFF
) (
  // Clock and reset.
  input  wire logic               core_clk,
  input  wire logic               reset,
  // Software set and clear masks, hardware set requests.
  input  wire oeil_pkg::oeil_word_t sw_set,
  input  wire oeil_pkg::oeil_word_t sw_clr,
  input  wire oeil_pkg::oeil_word_t hw_set,
  // Stored value.
  output oeil_pkg::oeil_word_t    q_ff
);

  oeil_pkg::oeil_word_t nxt_q;

  // Ones set or clear, zeros hold; a hardware set wins over a clear.
  assign nxt_q = (((q_ff | sw_set) & ~sw_clr) | hw_set) & IMPL_MASK; // R20

  always_ff @(posedge core_clk) begin
    if (reset) begin
      q_ff <= `OEIL_ZERO; // R7
    end else begin
      q_ff <= nxt_q;
    end
  end

endmodule : oeil_setclr_reg

// ===== tb/oeil_top_asserts.sv
`timescale 1ns/10ps
`include "oeil_params.svh"

module oeil_top_asserts (
  // Clock and reset.
  input wire logic                 core_clk,
  input wire logic                 reset,
  // Register port.
  input wire logic [`OEIL_AW-1:0]  reg_addr,
  input wire logic                 reg_wr_en,
  input wire logic                 reg_rd_en,
  input wire oeil_pkg::oeil_word_t reg_wdata,
  input wire oeil_pkg::oeil_word_t reg_rdata_ff,
  input wire logic                 reg_rdata_valid_ff,
  input wire logic                 reg_access_err_ff,
  // Monitor lines and events.
  input wire logic                 long_single_ended_zero_idle,
  input wire logic                 session_end_low_bus_voltage,
  input wire logic                 remote_connect_detect,
  input wire logic                 cable_type_pin,
  input wire logic                 dplus_pulse_session_request,
  input wire logic                 session_valid,
  input wire logic                 bus_power_valid,
  input wire logic                 role_timer_expired,
  input wire logic                 b_disconnect_a_connect_event,
  input wire logic                 j_to_k_resume_event,
  // Interrupt and state view.
  input wire logic                 otg_irq_ff,
  input wire oeil_pkg::oeil_word_t otg_live_condition_status_ff,
  input wire oeil_pkg::oeil_word_t otg_latch_ff
);
  logic mapped;
  logic wr_t9;
  assign mapped = reg_addr inside {16'h0378, 16'h037C, 16'h037E, 16'h0380,
                                   16'h0382, 16'h0384, 16'h0386};
  assign wr_t9  = reg_wr_en && reg_addr == `OEIL_ADDR_LATCH_SET
                  && reg_wdata[9];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_read_answered: assert property (reg_rd_en |=> reg_rdata_valid_ff)
    else $error("read not answered in the next cycle");
  a_valid_needs_read: assert property (reg_rdata_valid_ff
    |-> $past(reg_rd_en)) else $error("read valid without a read");
  a_unmapped_err: assert property ((reg_wr_en || reg_rd_en) && !mapped
    |=> reg_access_err_ff && (!$past(reg_rd_en) || reg_rdata_ff == 16'h0000))
    else $error("unmapped access not refused");
  a_status_ro_err: assert property (reg_wr_en && reg_addr == 16'h0378
    |=> reg_access_err_ff) else $error("status write not refused");
  a_status_reserved: assert property (otg_live_condition_status_ff[15:9] == 7'h00
    && otg_live_condition_status_ff[6:5] == 2'h0) else $error("status reserved bit set");
  a_latch_reserved: assert property (otg_latch_ff[15:10] == 6'h00)
    else $error("latch reserved bit set");
  a_latch_set_write: assert property (reg_wr_en && reg_addr == 16'h037C
    |=> (otg_latch_ff & $past(reg_wdata) & 16'h03FF) ==
        ($past(reg_wdata) & 16'h03FF)) else $error("latch set write lost");
  a_irq_follows: assert property (otg_irq_ff ==
    ($past(otg_latch_ff) != 16'h0000))
    else $error("interrupt request does not follow latch");
  a_cable_live: assert property ($stable(cable_type_pin) [*4]
    |-> otg_live_condition_status_ff[3] == cable_type_pin) else $error("cable bit stale");
  a_power_live: assert property ($stable(bus_power_valid) [*4]
    |-> otg_live_condition_status_ff[0] == bus_power_valid) else $error("power bit stale");
  a_timer_cause: assert property ($rose(otg_latch_ff[9]) |->
    $past(wr_t9) || $past(role_timer_expired, 2) ||
    $past(role_timer_expired, 3))
    else $error("timer latch bit set without cause");

  c_unmapped: cover property (reg_rd_en && !mapped);
  c_irq_rise: cover property ($rose(otg_irq_ff));
  c_irq_fall: cover property ($fell(otg_irq_ff));
endmodule : oeil_top_asserts

bind oeil_top oeil_top_asserts u_oeil_top_asserts (.core_clk, .reset,
  .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata, .reg_rdata_ff,
  .reg_rdata_valid_ff, .reg_access_err_ff, .long_single_ended_zero_idle,
  .session_end_low_bus_voltage, .remote_connect_detect, .cable_type_pin,
  .dplus_pulse_session_request, .session_valid, .bus_power_valid,
  .role_timer_expired, .b_disconnect_a_connect_event, .j_to_k_resume_event,
  .otg_irq_ff, .otg_live_condition_status_ff, .otg_latch_ff);

// ===== tb/oeil_host_model.sv
`timescale 1ns/10ps

module oeil_host_model (
  // Clock.
  input  wire logic                 core_clk,
  // Requests.
  output logic [15:0]               reg_addr,
  output logic                      reg_wr_en,
  output logic                      reg_rd_en,
  output oeil_pkg::oeil_word_t      reg_wdata,
  // Answers.
  input  wire oeil_pkg::oeil_word_t reg_rdata_ff,
  input  wire logic                 reg_rdata_valid_ff,
  input  wire logic                 reg_access_err_ff
);
  int idle_cycles = 0;
  initial begin
    reg_addr  = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
  end
  // Released lines show the inverse of their last value.
  task automatic wr(input logic [15:0] a, input oeil_pkg::oeil_word_t d,
                    output logic err);
    repeat (idle_cycles) @(posedge core_clk);
    @(posedge core_clk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr_en = 1'b0;
    err       = reg_access_err_ff;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [15:0] a, output oeil_pkg::oeil_word_t d,
                    output logic err, output logic ok);
    repeat (idle_cycles) @(posedge core_clk);
    @(posedge core_clk);
    #1;
    reg_addr  = a;
    reg_rd_en = 1'b1;
    @(posedge core_clk);
    #1;
    reg_rd_en = 1'b0;
    ok        = reg_rdata_valid_ff;
    d         = reg_rdata_ff;
    err       = reg_access_err_ff;
    reg_addr  = ~a;
  endtask : rd
endmodule : oeil_host_model

// ===== tb/testbench.sv
`timescale 1ns/10ps

module testbench;
  logic                 core_clk;
  logic                 reset;
  logic [15:0]          reg_addr;
  logic                 reg_wr_en;
  logic                 reg_rd_en;
  oeil_pkg::oeil_word_t reg_wdata;
  oeil_pkg::oeil_word_t reg_rdata_ff;
  logic                 reg_rdata_valid_ff;
  logic                 reg_access_err_ff;
  logic                 otg_irq_ff;
  oeil_pkg::oeil_word_t otg_live_condition_status_ff;
  oeil_pkg::oeil_word_t otg_latch_ff;
  logic [6:0]           lines;
  logic [2:0]           evts;
  int                   miscompares = 0;
  int                   comparisons = 0;
  int                   bit_of [7] = '{0, 1, 2, 3, 4, 7, 8};
  int                   ev_bit [3] = '{5, 6, 9};

  oeil_top u_oeil_top (.core_clk, .reset, .reg_addr, .reg_wr_en, .reg_rd_en,
    .reg_wdata, .reg_rdata_ff, .reg_rdata_valid_ff, .reg_access_err_ff,
    .long_single_ended_zero_idle(lines[6]),
    .session_end_low_bus_voltage(lines[5]),
    .remote_connect_detect(lines[4]), .cable_type_pin(lines[3]),
    .dplus_pulse_session_request(lines[2]), .session_valid(lines[1]),
    .bus_power_valid(lines[0]), .j_to_k_resume_event(evts[0]),
    .b_disconnect_a_connect_event(evts[1]), .role_timer_expired(evts[2]),
    .otg_irq_ff, .otg_live_condition_status_ff, .otg_latch_ff);
  oeil_host_model u_oeil_host_model (.core_clk, .reg_addr, .reg_wr_en,
    .reg_rd_en, .reg_wdata, .reg_rdata_ff, .reg_rdata_valid_ff,
    .reg_access_err_ff);

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic end_sim();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic chk(input string what, input oeil_pkg::oeil_word_t e,
                     input oeil_pkg::oeil_word_t g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input oeil_pkg::oeil_word_t d,
                    input logic ee);
    logic er;
    u_oeil_host_model.wr(a, d, er);
    chk("write error", {15'h0000, ee}, {15'h0000, er});
  endtask : wr

  task automatic rd(input logic [15:0] a, input oeil_pkg::oeil_word_t e,
                    input logic ee);
    oeil_pkg::oeil_word_t d;
    logic er;
    logic ok;
    u_oeil_host_model.rd(a, d, er, ok);
    chk("read valid", 16'h0001, {15'h0000, ok});
    chk("read data", e, d);
    chk("read error", {15'h0000, ee}, {15'h0000, er});
  endtask : rd

  function automatic oeil_pkg::oeil_word_t st_exp();
    st_exp = 16'h0000;
    for (int i = 0; i < 7; i++) st_exp[bit_of[i]] = lines[i];
  endfunction : st_exp

  task automatic t_reset();
    rd(16'h0378, st_exp(), 1'b0);
    rd(16'h037C, 16'h0000, 1'b0);
    rd(16'h0380, 16'h0000, 1'b0);
    rd(16'h0384, 16'h0000, 1'b0);
  endtask : t_reset

  task automatic t_status();
    for (int i = 0; i < 7; i++) begin
      lines[i] = ~lines[i];
      cyc(4);
      rd(16'h0378, st_exp(), 1'b0);
      chk("latch idle", 16'h0000, otg_latch_ff);
    end
  endtask : t_status

  task automatic t_setclr();
    wr(16'h0380, 16'hFFFF, 1'b1);
    rd(16'h0382, 16'h019B, 1'b0);
    wr(16'h0382, 16'h0001, 1'b0);
    rd(16'h0380, 16'h019A, 1'b0);
    wr(16'h0382, 16'h019A, 1'b0);
    wr(16'h0384, 16'hFFFF, 1'b1);
    rd(16'h0386, 16'h03FF, 1'b0);
    wr(16'h0386, 16'h03FF, 1'b0);
    wr(16'h037C, 16'h0600, 1'b1);
    rd(16'h037E, 16'h0200, 1'b0);
    chk("irq set", 16'h0001, {15'h0000, otg_irq_ff});
    wr(16'h037E, 16'h0200, 1'b0);
    cyc(1);
    chk("irq clear", 16'h0000, {15'h0000, otg_irq_ff});
  endtask : t_setclr

  task automatic t_fall();
    for (int i = 0; i < 7; i++) begin
      lines[i] = 1'b0;
      cyc(5);
      wr(16'h0380, 16'h0001 << bit_of[i], bit_of[i] == 2);
      lines[i] = 1'b1;
      cyc(6);
      chk("rise ignored", 16'h0000, otg_latch_ff);
      lines[i] = 1'b0;
      cyc(6);
      chk("fall latch", bit_of[i] == 2 ? 16'h0000 : 16'h0001 << bit_of[i],
          otg_latch_ff);
      wr(16'h0382, 16'h019B, 1'b0);
      wr(16'h037E, 16'h03FF, 1'b0);
    end
  endtask : t_fall

  task automatic t_rise();
    wr(16'h0384, 16'h0268, 1'b0);
    for (int k = 0; k < 4; k++) begin
      if (k < 3) evts[k] = 1'b1;
      else lines[3] = 1'b1;
      cyc(1);
      evts = 3'b000;
      cyc(5);
      chk("rise latch", 16'h0001 << (k < 3 ? ev_bit[k] : 3),
          otg_latch_ff);
      wr(16'h037E, 16'h03FF, 1'b0);
    end
    wr(16'h0386, 16'h03FF, 1'b0);
    evts = 3'b111;
    cyc(1);
    evts = 3'b000;
    cyc(5);
    chk("disarmed", 16'h0000, otg_latch_ff);
  endtask : t_rise

  task automatic t_bad();
    rd(16'h0390, 16'h0000, 1'b1);
    wr(16'h0378, 16'hFFFF, 1'b1);
    rd(16'h0378, st_exp(), 1'b0);
  endtask : t_bad

  initial begin
    reset = 1'b1;
    lines = 7'b1101011;
    evts  = 3'b000;
    repeat (3) @(posedge core_clk);
    #1;
    chk("status in reset", st_exp() & 16'h008B, otg_live_condition_status_ff);
    reset = 1'b0;
    t_reset();
    t_status();
    t_setclr();
    t_fall();
    u_oeil_host_model.idle_cycles = 2;
    t_rise();
    t_bad();
    end_sim();
  end
endmodule : testbench
